// ---- hw/rtc_map.vh ----
// Constants for the reset and test-port control block
`ifndef RTC_MAP_VH
`define RTC_MAP_VH
`define RTC_NSTREAM 16
`define RTC_NCHAN 2
`define RTC_IR_LEN 4
`define RTC_IR_RESET 4'h1
`define RTC_IR_BYPASS 4'hF
`define RTC_IR_IDCODE 4'h2
`define RTC_IR_CAPTURE 4'h1
`define RTC_ID_VALUE 32'h00000001
`define RTC_ID_LEN 32
`define RTC_ZERO1 1'h0
`define RTC_ONE1 1'h1
`define RTC_ALL_ONES 16'hFFFF
`define RTC_ALL_ZERO 16'h0000
`define RTC_CHAN_ZERO 2'h0
`define RTC_SYNC_N 7
`define RTC_SYNC_INIT 7'h0C
`define RTC_PIN_RST 0
`define RTC_PIN_TCK 1
`define RTC_PIN_TMS 2
`define RTC_PIN_TDI 3
`define RTC_PIN_TRST 4
`define RTC_PIN_LSEL 5
`define RTC_PIN_BSEL 6
`endif

// ---- hw/rtc_sync2.v ----
// Two-flop synchroniser for one level
`timescale 1ns/100ps
`default_nettype none
module rtc_sync2 #(
    parameter RESET_VAL = 1'h0
) (
    input wire clk,
    input wire rst,
    input wire din,
    output reg dout
);
    reg stage1;
    always @(posedge clk) begin
        if (rst) begin
            stage1 <= RESET_VAL;
            dout <= RESET_VAL;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule
`default_nettype wire

// ---- hw/rtc_reset_and_test_port_control.v ----
// Device reset handling and boundary-scan test port
// Notes on behaviour
// - Reset enters at once when pin falls; leaves in step with clock.
// - In reset, serial outputs go high or float per select pins.
// - Reset drives all channel buffer-control outputs low.
// - Reset raises coreResetActive; the TAP registers are not cleared by it.
// - TAP state machine advances on test clock per sampled TMS.
// - Instruction and data bits shift in from TDI on test clock.
// - Test data output changes only on falling test clock edges and when TRST clears it low.
// - Test data output floats when boundary scan is not enabled.
// - Low TRST forces Test-Logic-Reset at once, without test clock.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_map.vh"
module rtc_reset_and_test_port_control (
    input wire clk,
    input wire rst,
    input wire resetPinN,
    input wire local_out_reset_state_sel,
    input wire backplane_out_reset_state_sel,
    input wire [15:0] localDataIn,
    input wire [15:0] backplaneDataIn,
    input wire [1:0] localChanEnIn,
    input wire [1:0] backplaneChanEnIn,
    input wire tck,
    input wire tms,
    input wire tdi,
    input wire trstN,
    output reg [15:0] local_serial_out,
    output reg [15:0] local_serial_out_oe,
    output reg [15:0] backplane_serial_out,
    output reg [15:0] backplane_serial_out_oe,
    output reg [1:0] local_chan_buffer_ctrl,
    output reg [1:0] backplane_chan_buffer_ctrl,
    output reg coreResetActive,
    output reg tdo,
    output reg tdoOe,
    output reg [3:0] tapState
);
    localparam TLR = 4'h0;
    localparam RTI = 4'h1;
    localparam SDR = 4'h2;
    localparam CDR = 4'h3;
    localparam SHDR = 4'h4;
    localparam E1DR = 4'h5;
    localparam PDR = 4'h6;
    localparam E2DR = 4'h7;
    localparam UDR = 4'h8;
    localparam SIR = 4'h9;
    localparam CIR = 4'hA;
    localparam SHIR = 4'hB;
    localparam E1IR = 4'hC;
    localparam PIR = 4'hD;
    localparam E2IR = 4'hE;
    localparam UIR = 4'hF;

    // Strap decode shared by both ports: high selects floating
    function [15:0] resetEnable;
        input sel;
        begin
            resetEnable = sel ? `RTC_ALL_ZERO : `RTC_ALL_ONES;
        end
    endfunction

    // Only shift states drive the test output, so it floats otherwise
    function isShift;
        input [3:0] state;
        begin
            isShift = (state == SHDR) | (state == SHIR);
        end
    endfunction

    // Pin inputs cross into the core domain
    // Idle levels: mode and data lines sit high, the rest low
    localparam [`RTC_SYNC_N-1:0] SYNC_INIT = `RTC_SYNC_INIT;
    wire [`RTC_SYNC_N-1:0] pinRaw;
    wire [`RTC_SYNC_N-1:0] pinSync;
    wire rstPinSync;
    wire tckS;
    wire tmsS;
    wire tdiS;
    wire trstS;
    wire lSel;
    wire bSel;
    assign pinRaw[`RTC_PIN_RST] = resetPinN;
    assign pinRaw[`RTC_PIN_TCK] = tck;
    assign pinRaw[`RTC_PIN_TMS] = tms;
    assign pinRaw[`RTC_PIN_TDI] = tdi;
    assign pinRaw[`RTC_PIN_TRST] = trstN;
    assign pinRaw[`RTC_PIN_LSEL] = local_out_reset_state_sel;
    assign pinRaw[`RTC_PIN_BSEL] = backplane_out_reset_state_sel;
    genvar gi;
    generate
        for (gi = 0; gi < `RTC_SYNC_N; gi = gi + 1) begin : gSync
            rtc_sync2 #(
                .RESET_VAL(SYNC_INIT[gi])
            ) uSync (
                .clk(clk),
                .rst(rst),
                .din(pinRaw[gi]),
                .dout(pinSync[gi])
            );
        end
    endgenerate
    assign rstPinSync = pinSync[`RTC_PIN_RST];
    assign tckS = pinSync[`RTC_PIN_TCK];
    assign tmsS = pinSync[`RTC_PIN_TMS];
    assign tdiS = pinSync[`RTC_PIN_TDI];
    assign trstS = pinSync[`RTC_PIN_TRST];
    assign lSel = pinSync[`RTC_PIN_LSEL];
    assign bSel = pinSync[`RTC_PIN_BSEL];

    // Entry is taken from the raw pin so reset does not wait for sync
    wire inReset = rst | ~resetPinN | ~rstPinSync;
    wire trstNow = rst | ~trstN | ~trstS;

    // Output stage: reset state or pass-through
    always @(posedge clk) begin
        coreResetActive <= inReset;
        if (inReset) begin
            local_serial_out <= `RTC_ALL_ONES;
            local_serial_out_oe <= resetEnable(lSel);
            local_chan_buffer_ctrl <= `RTC_CHAN_ZERO;
        end else begin
            local_serial_out <= localDataIn;
            local_serial_out_oe <= `RTC_ALL_ONES;
            local_chan_buffer_ctrl <= localChanEnIn;
        end
    end

    // Backplane port mirrors the local one with its own strap
    always @(posedge clk) begin
        if (inReset) begin
            backplane_serial_out <= `RTC_ALL_ONES;
            backplane_serial_out_oe <= resetEnable(bSel);
            backplane_chan_buffer_ctrl <= `RTC_CHAN_ZERO;
        end else begin
            backplane_serial_out <= backplaneDataIn;
            backplane_serial_out_oe <= `RTC_ALL_ONES;
            backplane_chan_buffer_ctrl <= backplaneChanEnIn;
        end
    end

    // Test clock edges found by sampling
    reg tckPrev;
    always @(posedge clk) begin
        if (rst)
            tckPrev <= `RTC_ZERO1;
        else
            tckPrev <= tckS;
    end
    wire tckRise = tckS & ~tckPrev;
    wire tckFall = ~tckS & tckPrev;

    reg [3:0] next_tapState;
    always @* begin
        next_tapState = tapState;
        case (tapState)
            TLR: next_tapState = tmsS ? TLR : RTI;
            RTI: next_tapState = tmsS ? SDR : RTI;
            SDR: next_tapState = tmsS ? SIR : CDR;
            CDR: next_tapState = tmsS ? E1DR : SHDR;
            SHDR: next_tapState = tmsS ? E1DR : SHDR;
            E1DR: next_tapState = tmsS ? UDR : PDR;
            PDR: next_tapState = tmsS ? E2DR : PDR;
            E2DR: next_tapState = tmsS ? UDR : SHDR;
            UDR: next_tapState = tmsS ? SDR : RTI;
            SIR: next_tapState = tmsS ? TLR : CIR;
            CIR: next_tapState = tmsS ? E1IR : SHIR;
            SHIR: next_tapState = tmsS ? E1IR : SHIR;
            E1IR: next_tapState = tmsS ? UIR : PIR;
            PIR: next_tapState = tmsS ? E2IR : PIR;
            E2IR: next_tapState = tmsS ? UIR : SHIR;
            UIR: next_tapState = tmsS ? SDR : RTI;
            default: next_tapState = TLR;
        endcase
    end

    reg [3:0] irShift;
    reg [3:0] irActive;
    reg [31:0] drShift;
    reg bypassBit;
    wire isBypass = (irActive != `RTC_IR_IDCODE);
    always @(posedge clk) begin
        if (trstNow) begin
            tapState <= TLR;
            irShift <= `RTC_IR_RESET;
            irActive <= `RTC_IR_IDCODE;
            drShift <= `RTC_ID_VALUE;
            bypassBit <= `RTC_ZERO1;
        end else if (tckRise) begin
            tapState <= next_tapState;
            if (tapState == TLR)
                irActive <= `RTC_IR_IDCODE;
            case (tapState)
                CIR: irShift <= `RTC_IR_CAPTURE;
                SHIR: irShift <= {tdiS, irShift[3:1]};
                UIR: irActive <= irShift;
                CDR: begin
                    drShift <= `RTC_ID_VALUE;
                    bypassBit <= `RTC_ZERO1;
                end
                SHDR: begin
                    drShift <= {tdiS, drShift[31:1]};
                    bypassBit <= tdiS;
                end
                default: irShift <= irShift;
            endcase
        end
    end

    // Output launched on falling edge, floats outside shift states
    always @(posedge clk) begin
        if (trstNow) begin
            tdo <= `RTC_ZERO1;
            tdoOe <= `RTC_ZERO1;
        end else if (tckFall) begin
            tdoOe <= isShift(tapState);
            if (tapState == SHIR)
                tdo <= irShift[0];
            else
                tdo <= isBypass ? bypassBit : drShift[0];
        end
    end
endmodule
`default_nettype wire

// ---- bench/rtc_props.sv ----
// Checker for the reset and test-port block
`timescale 1ns/100ps
`default_nettype none
module rtc_props (
    input wire logic clk,
    input wire logic rst,
    input wire logic resetPinN,
    input wire logic local_out_reset_state_sel,
    input wire logic tck,
    input wire logic trstN,
    input wire logic coreResetActive,
    input wire logic tdo,
    input wire logic tdoOe,
    input wire logic [15:0] local_serial_out_oe,
    input wire logic [1:0] local_chan_buffer_ctrl,
    input wire logic [3:0] tapState
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    float_sel_a: assert property (
        (!resetPinN && $stable(local_out_reset_state_sel)) [*3] |=>
        local_serial_out_oe == {16{!$past(local_out_reset_state_sel)}})
        else $error("serial enable wrong in reset");
    buf_low_a: assert property (
        !resetPinN |=> local_chan_buffer_ctrl == 2'h0) else $error("buf on");
    core_clear_a: assert property (
        !resetPinN [*2] |=> coreResetActive) else $error("core not reset");
    sync_leave_a: assert property (
        $rose(resetPinN) |-> (local_chan_buffer_ctrl == 2'h0) [*3])
        else $error("reset left too early");
    tap_trst_a: assert property (!trstN |=> tapState == 4'h0)
        else $error("tap not forced to reset");
    tdo_float_a: assert property (!trstN |=> !tdoOe)
        else $error("tdo driven while test logic off");
    tdo_fall_a: assert property ($changed(tdo) |-> !$past(tck, 2))
        else $error("tdo moved outside falling edge");
    tap_step_a: assert property (
        $changed(tapState) && $past(trstN) |-> $past(tck, 2))
        else $error("tap moved without test clock rise");
endmodule
bind rtc_reset_and_test_port_control rtc_props chk (.clk, .rst,
    .resetPinN, .local_out_reset_state_sel, .tck, .trstN, .coreResetActive,
    .tdo, .tdoOe, .local_serial_out_oe, .local_chan_buffer_ctrl, .tapState);
`default_nettype wire

// ---- bench/rtc_tap_host.sv ----
// Scan tester model: test clock and mode line
`timescale 1ns/100ps
`default_nettype none
module rtc_tap_host (
    input wire logic run,
    input wire logic [15:0] tmsPat,
    output var logic tck,
    output var logic tms
);
    int idx = 0;
    // Odd offset keeps test clock edges off core clock edges
    initial begin
        tck = 0;
        #1.3;
        forever begin
            #80;
            // Stands low between frames; mode line moves on each fall
            if (run || tck) begin
                tck = ~tck;
                if (!tck)
                    idx = idx + 1;
            end
        end
    end
    always_comb tms = tmsPat[idx];
endmodule
`default_nettype wire

// ---- bench/rtc_reset_and_test_port_control_tb_top.sv ----
// Bench for the reset and test-port block
`timescale 1ns/100ps
`default_nettype none
module rtc_reset_and_test_port_control_tb_top;
    logic clk = 0, rst = 1, resetPinN = 1, tdi = 0, run = 0;
    logic trstN = 0;
    logic local_out_reset_state_sel = 0, backplane_out_reset_state_sel = 0;
    logic [15:0] localDataIn = 16'hA5C3, backplaneDataIn = 16'h3C5A;
    logic [15:0] tmsPat = 16'h005F;
    logic [1:0] localChanEnIn = 2'h2, backplaneChanEnIn = 2'h1;
    logic tck, tms, coreResetActive, tdo, tdoOe;
    logic [15:0] local_serial_out, local_serial_out_oe;
    logic [15:0] backplane_serial_out, backplane_serial_out_oe;
    logic [1:0] local_chan_buffer_ctrl, backplane_chan_buffer_ctrl;
    logic [3:0] tapState;
    int errors = 0, tests_run = 0;
    always #2 clk = ~clk;
    rtc_reset_and_test_port_control dut (.clk, .rst, .resetPinN,
        .local_out_reset_state_sel, .backplane_out_reset_state_sel,
        .localDataIn, .backplaneDataIn, .localChanEnIn, .backplaneChanEnIn,
        .tck, .tms, .tdi, .trstN, .local_serial_out, .local_serial_out_oe,
        .backplane_serial_out, .backplane_serial_out_oe,
        .local_chan_buffer_ctrl, .backplane_chan_buffer_ctrl,
        .coreResetActive, .tdo, .tdoOe, .tapState);
    rtc_tap_host host (.run, .tmsPat, .tck, .tms);
    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_pin_reset(logic ls, logic bs);
        @(posedge clk);
        local_out_reset_state_sel <= ls;
        backplane_out_reset_state_sel <= bs;
        resetPinN <= 0;
        repeat (3) @(posedge clk);
        #1 chk("lso_oe", {16{!ls}}, local_serial_out_oe);
        chk("bso_oe", {16{!bs}}, backplane_serial_out_oe);
        if (!ls) chk("lso", 16'hFFFF, local_serial_out);
        if (!bs) chk("bso", 16'hFFFF, backplane_serial_out);
        chk("bufs", 0, {local_chan_buffer_ctrl, backplane_chan_buffer_ctrl});
        chk("core", 1, coreResetActive);
        @(posedge clk) resetPinN <= 1;
        repeat (2) @(posedge clk);
        #1 chk("early", 0, local_chan_buffer_ctrl);
        repeat (2) @(posedge clk);
        #1 chk("lso_run", localDataIn, local_serial_out);
        chk("bufs_run", {localChanEnIn, backplaneChanEnIn},
            {local_chan_buffer_ctrl, backplane_chan_buffer_ctrl});
        chk("bso_run", backplaneDataIn, backplane_serial_out);
        chk("lso_oe_run", 16'hFFFF, local_serial_out_oe);
        chk("bso_oe_run", 16'hFFFF, backplane_serial_out_oe);
        $display("test_pin_reset %0d%0d done", ls, bs);
    endtask
    task automatic test_tap_walk;
        @(posedge clk) trstN <= 1;
        repeat (4) @(posedge clk);
        #1 chk("oe_idle", 0, tdoOe);
        run = 1;
        repeat (9) @(negedge tck);
        run = 0;
        repeat (6) @(posedge clk);
        #1 chk("shift_dr", 4'h4, tapState);
        chk("tdo_bit0", 1, tdo);
        chk("tdo_on", 1, tdoOe);
        run = 1;
        @(negedge tck) run = 0;
        repeat (6) @(posedge clk);
        #1 chk("tdo_bit1", 0, tdo);
        @(posedge clk) trstN <= 0;
        repeat (2) @(posedge clk);
        #1 chk("tlr", 0, tapState);
        chk("oe_off", 0, tdoOe);
        $display("test_tap_walk done");
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 0;
        test_pin_reset(0, 1);
        test_pin_reset(1, 0);
        test_tap_walk();
        tally_and_finish();
    end
    initial begin
        #20000;
        errors++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
